// *** core/thermal_pkg.sv ***
package thermal_pkg;

  // Register byte addresses
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_TEMP = 12'h010;
  localparam logic [11:0] OFF_WARN_TH = 12'h014;
  localparam logic [11:0] OFF_CRIT_TH = 12'h018;
  localparam logic [11:0] OFF_FATAL_TH = 12'h01C;
  localparam logic [11:0] OFF_SHUT_TH = 12'h020;

  // Control fields
  localparam int CTRL_SHUT_EN_BIT = 0;
  localparam int CTRL_FORCE_OFF_BIT = 1;

  // Status fields
  localparam int ST_SHUT_LATCHED_BIT = 0;
  localparam int ST_WARN_BIT = 1;
  localparam int ST_CRIT_BIT = 2;
  localparam int ST_FATAL_BIT = 3;
  localparam int ST_POWER_OFF_BIT = 4;

  // Interrupt event fields
  localparam int EV_WARN_BIT = 0;
  localparam int EV_CRIT_BIT = 1;
  localparam int EV_FATAL_BIT = 2;
  localparam int EV_SHUT_BIT = 3;
  localparam int EV_RELEASE_BIT = 4;
  localparam int EV_WIDTH = 5;

  // Reset values (temperature codes, one per degree)
  localparam logic [7:0] RST_WARN_TH = 8'h5F;
  localparam logic [7:0] RST_CRIT_TH = 8'h69;
  localparam logic [7:0] RST_FATAL_TH = 8'h7D;
  localparam logic [7:0] RST_SHUT_TH = 8'h73;
  localparam logic RST_SHUT_EN = 1'b1;

  // Identify-only dwell time
  localparam int CLK_HZ = 40000000;
  localparam int ID_DWELL_MS = 20;
  localparam int ID_DWELL_CYC = (CLK_HZ / 1000) * ID_DWELL_MS;

  // Card power states
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ID,
    PWR_AUX,
    PWR_MAIN
  } pwr_state_t;

endpackage : thermal_pkg

// *** core/temp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface temp_if;
  logic sample_valid;
  logic [7:0] temp;
  logic id_release;
  modport src (output sample_valid, output temp, output id_release);
  modport dst (input sample_valid, input temp, input id_release);
endinterface : temp_if
`default_nettype wire

// *** core/temp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module temp_sync #(
  parameter int DWELL_CYC = thermal_pkg::ID_DWELL_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins from the sensor and power control
  input wire logic sample_pin_in,
  input wire logic [7:0] temp_pin_in,
  input wire logic [1:0] pwr_state_pin_in,
  // To the monitor
  temp_if.src tif
);
  // A zero dwell would let any glimpse of identify release the latch
  if (DWELL_CYC < 1) begin : g_bad_dwell
    $error("DWELL_CYC must be positive");
  end

  typedef struct packed {
    logic [2:0] smp;
    logic [2:0][7:0] tmp;
    logic [2:0][1:0] pst;
    logic smp_last;
    logic [31:0] dwell;
    logic released;
    logic valid;
    logic [7:0] temp;
    logic rel;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.smp = {s_reg.smp[1:0], sample_pin_in};
    s_next.tmp = {s_reg.tmp[1:0], temp_pin_in};
    s_next.pst = {s_reg.pst[1:0], pwr_state_pin_in};
    s_next.valid = 1'b0;
    s_next.rel = 1'b0;
    // Strobe counts once stages two and three agree
    if (s_reg.smp[1] == s_reg.smp[2]) begin
      s_next.smp_last = s_reg.smp[2];
      if (s_reg.smp[2] && !s_reg.smp_last) begin
        s_next.valid = 1'b1;
        s_next.temp = s_reg.tmp[2];
      end
    end
    if (s_reg.pst[1] == s_reg.pst[2] && s_reg.pst[2] == thermal_pkg::PWR_ID) begin
      if (s_reg.dwell < 32'(DWELL_CYC)) begin
        s_next.dwell = s_reg.dwell + 32'h1;
      end else if (!s_reg.released) begin
        // release only after a full pass
        s_next.rel = 1'b1;
        s_next.released = 1'b1;
      end
    end else if (s_reg.pst[1] == s_reg.pst[2]) begin
      s_next.dwell = '0;
      s_next.released = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tif.sample_valid = s_reg.valid;
  assign tif.temp = s_reg.temp;
  assign tif.id_release = s_reg.rel;
endmodule : temp_sync
`default_nettype wire

// *** core/thermal_self_shutdown_monitor.sv ***
// Behaviour
// - Compare own temperature with shutdown threshold, power down when reached.
// - Shutdown acts on its own, no management command needed.
// - Shutdown cuts controller silicon power, not the card supply.
// - Shutdown latched; never resumes by itself when temperature falls.
// - Only a pass through identify-only state releases the latch.
// - Enable control; when disabled, threshold crossing does not power down.
// - Recommended: shutdown threshold above maximum junction temperature.
// - Recommended: shutdown threshold between critical and fatal thresholds.
// - Warning, critical and fatal thresholds readable by management.
// - Temperature readable in auxiliary and main power states.
// - Identify-only state must last at least 20 ms before release.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module thermal_self_shutdown_monitor #(
  parameter int DWELL_CYC = thermal_pkg::ID_DWELL_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Sensor and card power pins
  input wire logic SAMPLE_IN,
  input wire logic [7:0] TEMP_IN,
  input wire logic [1:0] PWR_STATE_IN,
  // Controller silicon power gate and interrupt
  output logic ASIC_PWR_EN_OUT,
  output logic SHUTDOWN_OUT,
  output logic IRQ_OUT
);
  ////////////////////////////////////////////////////////////////////////////

  // A zero dwell would let any glimpse of identify release the latch
  if (DWELL_CYC < 1) begin : g_bad_dwell
    $error("DWELL_CYC must be positive");
  end
  // Every field must fit one bus word
  if (thermal_pkg::EV_WIDTH > 32 || thermal_pkg::ST_POWER_OFF_BIT > 31) begin : g_bad_layout
    $error("Register fields exceed the bus word");
  end

  ////////////////////////////////////////////////////////////////////////////

  temp_if tif();

  temp_sync #(
    .DWELL_CYC(DWELL_CYC)
  ) u_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .sample_pin_in(SAMPLE_IN),
    .temp_pin_in(TEMP_IN),
    .pwr_state_pin_in(PWR_STATE_IN),
    .tif(tif.src)
  );

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic shut_en;
    logic force_off;
    logic latched;
    logic [7:0] temp;
    logic [7:0] warn_th;
    logic [7:0] crit_th;
    logic [7:0] fatal_th;
    logic [7:0] shut_th;
    logic warn;
    logic crit;
    logic fatal;
    logic [thermal_pkg::EV_WIDTH-1:0] irq_stat;
    logic [thermal_pkg::EV_WIDTH-1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pwr_en;
    logic irq;
  } mon_t;

  mon_t m_reg;
  mon_t m_next;

  ////////////////////////////////////////////////////////////////////////////

  // Zero-extend a byte field into a bus word
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction : word8

  // Unsigned compare; at-or-above so an exact hit trips
  function automatic logic crossed(input logic [7:0] t, input logic [7:0] th);
    crossed = t >= th;
  endfunction : crossed

  // Every offset that answers on the bus
  function automatic logic mapped(input logic [11:0] a);
    unique case (a)
      thermal_pkg::OFF_CTRL,
      thermal_pkg::OFF_STATUS,
      thermal_pkg::OFF_IRQ_STAT,
      thermal_pkg::OFF_IRQ_MASK,
      thermal_pkg::OFF_TEMP,
      thermal_pkg::OFF_WARN_TH,
      thermal_pkg::OFF_CRIT_TH,
      thermal_pkg::OFF_FATAL_TH,
      thermal_pkg::OFF_SHUT_TH: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  endfunction : mapped

  // Status and temperature reflect hardware, so writes are refused
  function automatic logic writable(input logic [11:0] a);
    writable = mapped(a);
    if (a == thermal_pkg::OFF_STATUS || a == thermal_pkg::OFF_TEMP) begin
      writable = 1'b0;
    end
  endfunction : writable

  // Control word as software reads it
  function automatic logic [31:0] ctrl_word(input mon_t m);
    ctrl_word = 32'h00000000;
    ctrl_word[thermal_pkg::CTRL_SHUT_EN_BIT] = m.shut_en;
    ctrl_word[thermal_pkg::CTRL_FORCE_OFF_BIT] = m.force_off;
  endfunction : ctrl_word

  // Status word; power-off mirrors the registered gate, not its next value
  function automatic logic [31:0] status_word(input mon_t m);
    status_word = 32'h00000000;
    status_word[thermal_pkg::ST_SHUT_LATCHED_BIT] = m.latched;
    status_word[thermal_pkg::ST_WARN_BIT] = m.warn;
    status_word[thermal_pkg::ST_CRIT_BIT] = m.crit;
    status_word[thermal_pkg::ST_FATAL_BIT] = m.fatal;
    status_word[thermal_pkg::ST_POWER_OFF_BIT] = !m.pwr_en;
  endfunction : status_word

  // Event bits padded into a bus word
  function automatic logic [31:0] event_word(input logic [thermal_pkg::EV_WIDTH-1:0] e);
    event_word = 32'h00000000;
    event_word[thermal_pkg::EV_WIDTH-1:0] = e;
  endfunction : event_word

  ////////////////////////////////////////////////////////////////////////////

  logic [thermal_pkg::EV_WIDTH-1:0] ev;
  logic acc;
  logic wr;

  always_comb begin
    m_next = m_reg;
    ev = '0;
    acc = PSEL_IN && PENABLE_IN && !m_reg.pready;
    wr = acc && PWRITE_IN;
    m_next.pready = acc;
    m_next.pslverr = 1'b0;

    if (tif.sample_valid) begin
      m_next.temp = tif.temp;
      m_next.warn = crossed(tif.temp, m_reg.warn_th);
      m_next.crit = crossed(tif.temp, m_reg.crit_th);
      m_next.fatal = crossed(tif.temp, m_reg.fatal_th);
      // Events only on a rise, so a steady hot reading is reported once
      ev[thermal_pkg::EV_WARN_BIT] = !m_reg.warn && m_next.warn;
      ev[thermal_pkg::EV_CRIT_BIT] = !m_reg.crit && m_next.crit;
      ev[thermal_pkg::EV_FATAL_BIT] = !m_reg.fatal && m_next.fatal;
      if (m_reg.shut_en && !m_reg.latched && crossed(tif.temp, m_reg.shut_th)) begin
        m_next.latched = 1'b1;
        ev[thermal_pkg::EV_SHUT_BIT] = 1'b1;
      end
    end

    // flag clears with latch
    // Release wins over a same-cycle sample; next sample re-trips if still hot
    if (tif.id_release) begin
      m_next.latched = 1'b0;
      ev[thermal_pkg::EV_RELEASE_BIT] = 1'b1;
    end

    // Register writes; force_off lets management cut power too
    if (wr) begin
      unique case (PADDR_IN)
        thermal_pkg::OFF_CTRL: begin
          m_next.shut_en = PWDATA_IN[thermal_pkg::CTRL_SHUT_EN_BIT];
          m_next.force_off = PWDATA_IN[thermal_pkg::CTRL_FORCE_OFF_BIT];
        end
        thermal_pkg::OFF_IRQ_STAT: begin
          m_next.irq_stat = m_reg.irq_stat & ~PWDATA_IN[thermal_pkg::EV_WIDTH-1:0];
        end
        thermal_pkg::OFF_IRQ_MASK: begin
          m_next.irq_mask = PWDATA_IN[thermal_pkg::EV_WIDTH-1:0];
        end
        thermal_pkg::OFF_WARN_TH: begin
          m_next.warn_th = PWDATA_IN[7:0];
        end
        thermal_pkg::OFF_CRIT_TH: begin
          m_next.crit_th = PWDATA_IN[7:0];
        end
        thermal_pkg::OFF_FATAL_TH: begin
          m_next.fatal_th = PWDATA_IN[7:0];
        end
        thermal_pkg::OFF_SHUT_TH: begin
          m_next.shut_th = PWDATA_IN[7:0];
        end
        default: begin
        end
      endcase
      // Read-only or unmapped: refused, nothing changes
      m_next.pslverr = !writable(PADDR_IN);
    end

    // Set wins over write-one-to-clear
    m_next.irq_stat = m_next.irq_stat | ev;

    m_next.prdata = 32'h00000000;
    if (acc && !PWRITE_IN) begin
      unique case (PADDR_IN)
        thermal_pkg::OFF_CTRL: begin
          m_next.prdata = ctrl_word(m_reg);
        end
        thermal_pkg::OFF_STATUS: begin
          m_next.prdata = status_word(m_reg);
        end
        thermal_pkg::OFF_IRQ_STAT: begin
          m_next.prdata = event_word(m_reg.irq_stat);
        end
        thermal_pkg::OFF_IRQ_MASK: begin
          m_next.prdata = event_word(m_reg.irq_mask);
        end
        thermal_pkg::OFF_TEMP: begin
          m_next.prdata = word8(m_reg.temp);
        end
        thermal_pkg::OFF_WARN_TH: begin
          m_next.prdata = word8(m_reg.warn_th);
        end
        thermal_pkg::OFF_CRIT_TH: begin
          m_next.prdata = word8(m_reg.crit_th);
        end
        thermal_pkg::OFF_FATAL_TH: begin
          m_next.prdata = word8(m_reg.fatal_th);
        end
        thermal_pkg::OFF_SHUT_TH: begin
          m_next.prdata = word8(m_reg.shut_th);
        end
        default: begin
        end
      endcase
      // Unmapped reads return zero and an error
      m_next.pslverr = !mapped(PADDR_IN);
    end

    m_next.pwr_en = !m_next.latched && !m_next.force_off;
    m_next.irq = |(m_next.irq_stat & m_next.irq_mask);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      m_reg <= '0;
      m_reg.shut_en <= thermal_pkg::RST_SHUT_EN;
      m_reg.warn_th <= thermal_pkg::RST_WARN_TH;
      m_reg.crit_th <= thermal_pkg::RST_CRIT_TH;
      m_reg.fatal_th <= thermal_pkg::RST_FATAL_TH;
      m_reg.shut_th <= thermal_pkg::RST_SHUT_TH;
      m_reg.pwr_en <= 1'b1;
    end else begin
      m_reg <= m_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign PRDATA_OUT = m_reg.prdata;
  assign PREADY_OUT = m_reg.pready;
  assign PSLVERR_OUT = m_reg.pslverr;
  assign ASIC_PWR_EN_OUT = m_reg.pwr_en;
  assign SHUTDOWN_OUT = m_reg.latched;
  assign IRQ_OUT = m_reg.irq;
endmodule : thermal_self_shutdown_monitor
`default_nettype wire

// *** test/sensor_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module sensor_pins (
  // Clock
  input wire logic clk_in,
  // Sensor pins
  output logic sample_out,
  output logic [7:0] temp_out
);
  initial begin
    sample_out = 1'b0;
    temp_out = 8'h00;
  end
  // Strobe held 4 high, then low for 10; code inverted 4 after the fall so stale data is never seen
  task send(input logic [7:0] v);
    @(posedge clk_in);
    temp_out <= v;
    sample_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sample_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    temp_out <= ~v;
    repeat (6) @(posedge clk_in);
  endtask : send
endmodule : sensor_pins
`default_nettype wire

// *** test/thermal_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module thermal_asserts #(
  parameter int DWELL_CYC = 20
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // APB
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Pins
  input wire logic SAMPLE_IN,
  input wire logic [7:0] TEMP_IN,
  input wire logic [1:0] PWR_STATE_IN,
  input wire logic ASIC_PWR_EN_OUT,
  input wire logic SHUTDOWN_OUT,
  input wire logic IRQ_OUT
);
  logic en_reg;
  logic [7:0] th_reg;
  int id_cnt;
  logic wr_ok;
  assign wr_ok = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;
  // Raw pin dwell; the synchroniser only makes the real count later
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      en_reg <= thermal_pkg::RST_SHUT_EN;
      th_reg <= thermal_pkg::RST_SHUT_TH;
      id_cnt <= 0;
    end else begin
      if (wr_ok && PADDR_IN == thermal_pkg::OFF_CTRL) begin
        en_reg <= PWDATA_IN[0];
      end
      if (wr_ok && PADDR_IN == thermal_pkg::OFF_SHUT_TH) begin
        th_reg <= PWDATA_IN[7:0];
      end
      id_cnt <= (PWR_STATE_IN == 2'h1) ? id_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  a_ready_wait: assert property ($rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT)
    else $error("ready late");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  a_trip_hot: assert property (
    $rose(SAMPLE_IN) && en_reg && TEMP_IN >= th_reg |-> ##[3:9] SHUTDOWN_OUT)
    else $error("no trip");
  a_no_trip: assert property (
    $rose(SAMPLE_IN) && !(en_reg && TEMP_IN >= th_reg) && !SHUTDOWN_OUT
    |-> !SHUTDOWN_OUT [*8]) else $error("false trip");
  a_cut_power: assert property (SHUTDOWN_OUT |-> !ASIC_PWR_EN_OUT)
    else $error("power kept");
  a_latch_hold: assert property ($fell(SHUTDOWN_OUT) |-> id_cnt >= DWELL_CYC)
    else $error("early release");
  a_flag_read: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN == thermal_pkg::OFF_STATUS
    |-> PRDATA_OUT[0] == SHUTDOWN_OUT && PRDATA_OUT[4] == !ASIC_PWR_EN_OUT)
    else $error("bad flag");
  a_temp_read: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN == thermal_pkg::OFF_TEMP && PWR_STATE_IN[1]
    |-> !PSLVERR_OUT) else $error("temp refused");
endmodule : thermal_asserts
`default_nettype wire

// *** test/thermal_self_shutdown_monitor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module thermal_self_shutdown_monitor_test;
  localparam int DWELL = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] pwr = 2'h3;
  logic [31:0] prdata;
  logic pready, pslverr, sample, asic_en, shut, irq, en, lat;
  logic [7:0] temp, th, t;
  logic [7:0] rv [4];
  int fails, n_compared, seed, i;
  always #12.5 clk = ~clk;
  sensor_pins u_sensor_pins (.clk_in(clk), .sample_out(sample), .temp_out(temp));
  thermal_self_shutdown_monitor #(.DWELL_CYC(DWELL)) u_thermal_self_shutdown_monitor (
    .CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SAMPLE_IN(sample), .TEMP_IN(temp), .PWR_STATE_IN(pwr),
    .ASIC_PWR_EN_OUT(asic_en), .SHUTDOWN_OUT(shut), .IRQ_OUT(irq));
  task close_out;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, ex, input logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1);
    if (!w) chk(prdata, ex);
    chk({31'h0, pslverr}, {31'h0, er});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task smp(input logic [7:0] v);
    u_sensor_pins.send(v);
    t = v;
    if (en && v >= th) lat = 1'b1;
  endtask : smp
  function automatic logic [31:0] st();
    return {27'h0, lat, t >= thermal_pkg::RST_FATAL_TH, t >= thermal_pkg::RST_CRIT_TH,
      t >= thermal_pkg::RST_WARN_TH, lat};
  endfunction : st
  task cst;
    chk({31'h0, shut}, {31'h0, lat});
    chk({31'h0, asic_en}, {31'h0, ~lat});
    apb(1'b0, thermal_pkg::OFF_STATUS, 32'h0, st(), 1'b0);
  endtask : cst
  initial begin
    seed = 95402;
    en = 1'b1;
    lat = 1'b0;
    th = thermal_pkg::RST_SHUT_TH;
    t = 8'h00;
    rv = '{thermal_pkg::RST_WARN_TH, thermal_pkg::RST_CRIT_TH, thermal_pkg::RST_FATAL_TH, th};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, thermal_pkg::OFF_WARN_TH + 12'(i * 4), 32'h0, {24'h0, rv[i]}, 1'b0);
    end
    apb(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
    apb(1'b1, thermal_pkg::OFF_TEMP, 32'h5A, 32'h0, 1'b1);
    apb(1'b1, thermal_pkg::OFF_IRQ_MASK, 32'h8, 32'h0, 1'b0);
    smp(th - 8'h01);
    cst;
    smp(th);
    cst;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, thermal_pkg::OFF_IRQ_STAT, 32'h8, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, thermal_pkg::OFF_IRQ_STAT, 32'h0, 32'h3, 1'b0);
    smp(8'($random(seed)) & 8'h3F);
    cst;
    pwr <= 2'h2;
    apb(1'b0, thermal_pkg::OFF_TEMP, 32'h0, {24'h0, t}, 1'b0);
    // Short identify visit must not release
    pwr <= 2'h1;
    repeat (DWELL / 2) @(posedge clk);
    pwr <= 2'h2;
    repeat (DWELL + 10) @(posedge clk);
    cst;
    pwr <= 2'h1;
    repeat (DWELL + 10) @(posedge clk);
    lat = 1'b0;
    pwr <= 2'h3;
    repeat (8) @(posedge clk);
    cst;
    apb(1'b0, thermal_pkg::OFF_IRQ_STAT, 32'h0, 32'h13, 1'b0);
    apb(1'b1, thermal_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
    en = 1'b0;
    smp(th + (8'($random(seed)) & 8'h3F));
    cst;
    apb(1'b1, thermal_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0);
    en = 1'b1;
    apb(1'b0, thermal_pkg::OFF_CTRL, 32'h0, 32'h1, 1'b0);
    // Management cuts power on its own; the latch stays clear
    apb(1'b1, thermal_pkg::OFF_CTRL, 32'h3, 32'h0, 1'b0);
    chk({31'h0, asic_en}, 32'h0);
    chk({31'h0, shut}, 32'h0);
    apb(1'b0, thermal_pkg::OFF_CTRL, 32'h0, 32'h3, 1'b0);
    apb(1'b1, thermal_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0);
    chk({31'h0, asic_en}, 32'h1);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule : thermal_self_shutdown_monitor_test
bind thermal_self_shutdown_monitor thermal_asserts #(.DWELL_CYC(DWELL_CYC)) u_thermal_asserts (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SAMPLE_IN(SAMPLE_IN), .TEMP_IN(TEMP_IN),
  .PWR_STATE_IN(PWR_STATE_IN), .ASIC_PWR_EN_OUT(ASIC_PWR_EN_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT),
  .IRQ_OUT(IRQ_OUT));
`default_nettype wire
